// File: flash_command_security_ctrl.sv
// Flash command launch, protection and security control
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
module flash_command_security_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [2:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  input  wire logic              debugAccess,
  output logic      [7:0]        regRdata,
  input  wire logic              flashWr,
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic [7:0]        flashWdata,
  input  wire logic [7:0]        nvOptions,
  input  wire logic [7:0]        nvProtect,
  input  wire logic [63:0]       storedKey,
  input  wire logic              stopEntry,
  input  wire logic              arrayDone,
  input  wire logic              arrayBlank,
  output logic                   arrayStart,
  output logic      [7:0]        arrayCmd,
  output logic      [ADDR_W-1:0] arrayAddr,
  output logic      [7:0]        arrayData,
  output logic                   secured,
  output logic                   debugBlock,
  output logic                   vectorRedirectEn
);

  typedef enum {SEQ_IDLE, SEQ_DATA, SEQ_CMD} seq_t;

  typedef struct packed {
    logic              loaded;
    logic [7:0]        options;
    logic [1:0]        secState;
    logic [7:0]        config_;
    logic [7:0]        protect;
    logic [7:0]        divider;
    logic              divLoaded;
    logic [7:0]        command;
    logic              bufEmpty;
    logic              protViol;
    logic              accessErr;
    logic              arrayBlankF;
    seq_t              seq;
    logic [ADDR_W-1:0] seqAddr;
    logic [7:0]        seqData;
    logic              pendValid;
    logic [7:0]        pendCmd;
    logic [ADDR_W-1:0] pendAddr;
    logic [7:0]        pendData;
    logic              active;
    logic [7:0]        activeCmd;
    logic              start;
    logic [7:0]        rdata;
    logic              secFlag;
    logic              redirEn;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  //========================================================================
  // Decode helpers
  function automatic logic cmdLegal(input logic [7:0] c);
    cmdLegal = (c == CMD_BLANK_CHECK) || (c == CMD_BYTE_PROG) ||
               (c == CMD_BURST_PROG) || (c == CMD_PAGE_ERASE) ||
               (c == CMD_MASS_ERASE);
  endfunction : cmdLegal

  function automatic logic inKeyWindow(input logic [ADDR_W-1:0] a);
    inKeyWindow = (a >= KEY_BASE[ADDR_W-1:0]) &&
                  (a < KEY_BASE[ADDR_W-1:0] + ADDR_W'(KEY_BYTES));
  endfunction : inKeyWindow

  // Protected area sits above the boundary formed from bits 7:1
  function automatic logic isProtected(input logic [7:0] prot,
                                       input logic [ADDR_W-1:0] a,
                                       input logic [7:0] c);
    logic [ADDR_W-1:0] lastFree;
    lastFree = {prot[7:1], {PAGE_BITS{1'b1}}};
    if (prot[BIT_PROT_DISABLE])
      isProtected = 1'b0;
    else if (c == CMD_MASS_ERASE || c == CMD_BLANK_CHECK)
      isProtected = (c == CMD_MASS_ERASE);
    else
      isProtected = a > lastFree;
  endfunction : isProtected

  //========================================================================
  // Key checker: only secured firmware writes reach it
  logic keyAccess;
  logic keyWr;
  logic keyRestart;
  logic keyMatch;
  logic [ADDR_W-1:0] keyOffset;

  assign keyAccess  = st.config_[BIT_KEY_ACCESS];
  assign keyOffset  = flashAddr - KEY_BASE[ADDR_W-1:0];
  assign keyWr      = flashWr && keyAccess && !debugAccess &&
                      inKeyWindow(flashAddr) && st.loaded;
  assign keyRestart = regWr && regAddr == OFS_CONFIG &&
                      regWdata[BIT_KEY_ACCESS] && !keyAccess;

  unlock_key_checker u_key (
    .clk      (clk),
    .rstn     (rstn),
    .restart  (keyRestart),
    .keyWr    (keyWr),
    .keyIndex (keyOffset[2:0]),
    .keyData  (flashWdata),
    .storedKey(storedKey),
    .keyMatch (keyMatch)
  );

  //========================================================================
  // Write qualifiers
  logic busy;
  logic cfgWr;
  logic statWr;
  logic launchWr;
  logic cmdWr;
  logic seqFlashWr;
  logic pendCanQueue;

  assign busy       = st.active || st.pendValid;
  assign cfgWr      = regWr && regAddr == OFS_CONFIG;
  assign statWr     = regWr && regAddr == OFS_STATUS;
  assign launchWr   = statWr && regWdata[BIT_BUF_EMPTY];
  assign cmdWr      = regWr && regAddr == OFS_COMMAND;
  assign seqFlashWr = flashWr && !(keyAccess && inKeyWindow(flashAddr));
  // A queued burst needs a burst running and an empty buffer
  assign pendCanQueue = st.activeCmd == CMD_BURST_PROG &&
                        st.command == CMD_BURST_PROG &&
                        !st.pendValid;

  //========================================================================
  // Next-state logic for registers, sequencer and array handoff
  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;
    next_st.rdata = 8'h00;

    // Nonvolatile bytes copied once after every reset
    if (!st.loaded) begin
      next_st.loaded   = 1'b1;
      next_st.options  = nvOptions;
      next_st.secState = nvOptions[1:0];
      next_st.protect  = nvProtect;
    end

    // Register reads, data returned the next cycle
    if (regRd) begin
      if (regAddr == OFS_DIVIDER)
        next_st.rdata = {st.divLoaded, st.divider[6:0]};
      else if (regAddr == OFS_OPTIONS)
        next_st.rdata = {st.options[7:6], 4'h0, st.secState};
      else if (regAddr == OFS_CONFIG)
        next_st.rdata = {2'h0, st.config_[BIT_KEY_ACCESS], 5'h00};
      else if (regAddr == OFS_PROTECT)
        next_st.rdata = st.protect;
      else if (regAddr == OFS_STATUS)
        next_st.rdata = {st.bufEmpty, !busy, st.protViol,
                         st.accessErr, 1'b0, st.arrayBlankF, 2'h0};
      else if (regAddr == OFS_COMMAND)
        next_st.rdata = st.command;
      else
        next_st.rdata = 8'h00;
    end

    // Plain register writes
    if (regWr && regAddr == OFS_DIVIDER) begin
      next_st.divider   = regWdata;
      next_st.divLoaded = 1'b1;
    end
    if (cfgWr)
      next_st.config_ = {2'h0, regWdata[BIT_KEY_ACCESS], 5'h00};
    // Application writes to protection are dropped
    if (regWr && regAddr == OFS_PROTECT && debugAccess)
      next_st.protect = regWdata;

    // Key access dropping triggers the comparison
    if (cfgWr && keyAccess && !regWdata[BIT_KEY_ACCESS] &&
        st.options[BIT_BACKDOOR_EN] && keyMatch)
      next_st.secState = SEC_UNSECURED;

    // Error flags: software clears first so a same-cycle set wins
    if (statWr && regWdata[BIT_PROT_VIOL])
      next_st.protViol = 1'b0;
    if (statWr && regWdata[BIT_ACCESS_ERR])
      next_st.accessErr = 1'b0;
    if (stopEntry && busy)
      next_st.accessErr = 1'b1;

    // Command sequence: array write, command code, then launch
    if (seqFlashWr) begin
      if (st.seq == SEQ_IDLE && st.bufEmpty) begin
        next_st.seq     = SEQ_DATA;
        next_st.seqAddr = flashAddr;
        next_st.seqData = flashWdata;
      end else begin
        next_st.accessErr = 1'b1;
        next_st.seq       = SEQ_IDLE;
      end
    end else if (cmdWr) begin
      if (st.seq == SEQ_DATA) begin
        next_st.seq     = SEQ_CMD;
        next_st.command = regWdata;
      end else begin
        next_st.accessErr = 1'b1;
        next_st.seq       = SEQ_IDLE;
      end
    end else if (launchWr) begin
      next_st.seq = SEQ_IDLE;
      if (st.seq != SEQ_CMD || !cmdLegal(st.command))
        next_st.accessErr = 1'b1;
      else if (!st.divLoaded)
        next_st.accessErr = 1'b1;
      else if (busy && !pendCanQueue)
        next_st.accessErr = 1'b1;
      else if (isProtected(st.protect, st.seqAddr, st.command))
        next_st.protViol = 1'b1;
      else begin
        next_st.bufEmpty    = 1'b0;
        next_st.pendValid   = 1'b1;
        next_st.pendCmd     = st.command;
        next_st.pendAddr    = st.seqAddr;
        next_st.pendData    = st.seqData;
        next_st.arrayBlankF = 1'b0;
      end
    end

    // Array finishing; a passing blank check unsecures the part
    if (st.active && arrayDone) begin
      next_st.active = 1'b0;
      if (st.activeCmd == CMD_BLANK_CHECK && arrayBlank) begin
        next_st.arrayBlankF = 1'b1;
        next_st.secState    = SEC_UNSECURED;
      end
    end

    // Buffered command moves to the idle array, freeing the buffer
    if (st.pendValid && (!st.active || arrayDone)) begin
      next_st.active    = 1'b1;
      next_st.pendValid = 1'b0;
      next_st.activeCmd = st.pendCmd;
      next_st.start     = 1'b1;
      next_st.bufEmpty  = 1'b1;
    end

    // Output levels registered so the pins never see decode glitches
    next_st.secFlag = next_st.secState != SEC_UNSECURED;
    next_st.redirEn = !next_st.options[BIT_REDIRECT_DIS];
  end

  //========================================================================
  // State register; nonvolatile loads happen on the first clocked edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.seq      <= SEQ_IDLE;
      st.divider  <= RST_DIVIDER;
      st.config_  <= RST_CONFIG;
      st.command  <= RST_COMMAND;
      st.bufEmpty <= 1'b1;
      st.secFlag  <= 1'b1; // Cleared security code reads as secure
      st.redirEn  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  //========================================================================
  // Outputs straight from state
  assign regRdata         = st.rdata;
  assign arrayStart       = st.start;
  assign arrayCmd         = st.activeCmd;
  assign arrayAddr        = st.pendAddr;
  assign arrayData        = st.pendData;
  assign secured          = st.secFlag;
  assign debugBlock       = st.secFlag;
  assign vectorRedirectEn = st.redirEn;

  //========================================================================
  // Checks on the behaviour above
  chk_options_reload:
  assert property (@(posedge clk) disable iff (!rstn)
    !st.loaded |=> st.options == $past(nvOptions))
  else $error("options not loaded from nonvolatile byte");

  chk_key_disabled:
  assert property (@(posedge clk) disable iff (!rstn)
    st.loaded && !st.options[BIT_BACKDOOR_EN] && secured &&
    !(st.active && arrayDone) |=> secured)
  else $error("security dropped with backdoor disabled");

  chk_debug_block:
  assert property (@(posedge clk) disable iff (!rstn)
    debugBlock == (st.secState != SEC_UNSECURED))
  else $error("debug block disagrees with security field");

  chk_protect_user:
  assert property (@(posedge clk) disable iff (!rstn)
    st.loaded && regWr && regAddr == OFS_PROTECT && !debugAccess
    |=> $stable(st.protect))
  else $error("application write changed protection");

  chk_launch_clear:
  assert property (@(posedge clk) disable iff (!rstn)
    launchWr && st.seq == SEQ_CMD && cmdLegal(st.command) &&
    st.divLoaded && !busy &&
    !isProtected(st.protect, st.seqAddr, st.command)
    |=> !st.bufEmpty ##1 st.bufEmpty && arrayStart)
  else $error("launch did not clear then refill buffer flag");

  chk_viol_set:
  assert property (@(posedge clk) disable iff (!rstn)
    launchWr && st.seq == SEQ_CMD && cmdLegal(st.command) &&
    st.divLoaded && !busy &&
    isProtected(st.protect, st.seqAddr, st.command)
    |=> st.protViol && !arrayStart)
  else $error("protected command not flagged");

  chk_illegal_code:
  assert property (@(posedge clk) disable iff (!rstn)
    launchWr && st.seq == SEQ_CMD && !cmdLegal(st.command)
    |=> st.accessErr && !st.pendValid)
  else $error("illegal code did not raise access error");

  chk_no_divider:
  assert property (@(posedge clk) disable iff (!rstn)
    !st.divLoaded && !(regWr && regAddr == OFS_DIVIDER)
    |=> !arrayStart)
  else $error("array started before divider written");

  chk_blank_unsec:
  assert property (@(posedge clk) disable iff (!rstn)
    st.active && arrayDone && arrayBlank &&
    st.activeCmd == CMD_BLANK_CHECK
    |=> !secured && st.arrayBlankF)
  else $error("blank pass did not unsecure part");

endmodule : flash_command_security_ctrl

// File: flash_ctrl_pkg.sv
// Constants shared by the flash command and security controller
//==========================================================================
// Contract
// - Every reset copies the nonvolatile options byte into the options reg.
// - Backdoor enable bit 7 clear refuses any backdoor unlock.
// - Matching 8-byte key written in ascending order unsecures until reset.
// - Only secured firmware key writes count; debug writes never count.
// - Options bit 6 set disables vector redirection; clear enables it.
// - Security field 1:0 alone means unsecured; other codes mean secure.
// - While secure, unsecured sources and debug are blocked from memory.
// - A passing blank check sets the security field to 1:0 until reset.
// - Config bit 5 makes key-window writes key compares, else commands.
// - Protection loads at reset, always readable, only debug may write.
// - Protection bit 0 clear protects selected block; set unprotects all.
// - Bits 7:1 set end of unprotected area; high end refuses changes.
// - Writing 1 to bit 7 launches; cleared on launch, set when empty.
// - Only burst programs may queue behind a running operation.
// - Bit 6 sets when idle and empty, clears on launch, ignores writes.
// - Command touching protected location is ignored; sets w1c bit 5.
// - Bad sequence, no divider, stop while busy set w1c bit 4.
// - Blank check over erased array sets bit 2; valid launch clears it.
// - Codes 05 blank check, 20 byte program, 25 burst program.
// - Codes 40 erases one 512-byte page, 41 erases whole array.
// - Any other command code raises access error without executing.
// - Divider-loaded flag set by first divider write; gates program/erase.
package flash_ctrl_pkg;

  //========================================================================
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_DIVIDER = 3'h0;
  localparam logic [2:0] OFS_OPTIONS = 3'h1;
  localparam logic [2:0] OFS_CONFIG  = 3'h2;
  localparam logic [2:0] OFS_PROTECT = 3'h3;
  localparam logic [2:0] OFS_STATUS  = 3'h4;
  localparam logic [2:0] OFS_COMMAND = 3'h5;

  //========================================================================
  // Field positions
  localparam int BIT_BACKDOOR_EN   = 7;
  localparam int BIT_REDIRECT_DIS  = 6;
  localparam int BIT_KEY_ACCESS    = 5;
  localparam int BIT_PROT_DISABLE  = 0;
  localparam int BIT_BUF_EMPTY     = 7;
  localparam int BIT_CMD_COMPLETE  = 6;
  localparam int BIT_PROT_VIOL     = 5;
  localparam int BIT_ACCESS_ERR    = 4;
  localparam int BIT_ARRAY_BLANK   = 2;
  localparam int BIT_DIV_LOADED    = 7;

  //========================================================================
  // Security codes and reset values
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [7:0] RST_DIVIDER   = 8'h00;
  localparam logic [7:0] RST_CONFIG    = 8'h00;
  localparam logic [7:0] RST_COMMAND   = 8'h00;

  //========================================================================
  // Command codes
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROG   = 8'h20;
  localparam logic [7:0] CMD_BURST_PROG  = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE  = 8'h41;

  //========================================================================
  // Address layout: key window and 512-byte pages
  localparam logic [15:0] KEY_BASE   = 16'hFFB0;
  localparam int          KEY_BYTES  = 8;
  localparam int          PAGE_BITS  = 9;

endpackage : flash_ctrl_pkg

// File: unlock_key_checker.sv
// Sequential comparator for the eight-byte backdoor key
`timescale 1ns/1ns
module unlock_key_checker
  import flash_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        restart,
  input  wire logic        keyWr,
  input  wire logic [2:0]  keyIndex,
  input  wire logic [7:0]  keyData,
  input  wire logic [63:0] storedKey,
  output logic             keyMatch
);

  typedef struct packed {
    logic [3:0] count;
    logic       fail;
    logic       lastWr;
  } key_state_t;

  key_state_t st;
  key_state_t next_st;

  //========================================================================
  // Byte n must land at index n; gaps or back-to-back writes spoil it
  always_comb begin
    next_st = st;
    next_st.lastWr = keyWr;
    if (restart) begin
      next_st.count = 4'h0;
      next_st.fail  = 1'b0;
    end else if (keyWr) begin
      if (st.lastWr || st.count >= 4'(KEY_BYTES) ||
          {1'b0, keyIndex} != st.count ||
          storedKey[8*keyIndex +: 8] != keyData)
        next_st.fail = 1'b1;
      if (st.count < 4'(KEY_BYTES))
        next_st.count = st.count + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign keyMatch = (st.count == 4'(KEY_BYTES)) && !st.fail;

endmodule : unlock_key_checker

// File: flash_command_security_ctrl_tb.sv
// Self-checking bench for the flash command and security controller
`timescale 1ns/1ns
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin badCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module flash_command_security_ctrl_tb import flash_ctrl_pkg::*;;
  //==========================================================================
  // Stimulus and observed signals
  logic        clk;
  logic        rstn;
  logic [2:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic        debugAccess;
  logic [7:0]  regRdata;
  logic        flashWr;
  logic [15:0] flashAddr;
  logic [7:0]  flashWdata;
  logic [7:0]  nvOptions;
  logic [7:0]  nvProtect;
  logic [63:0] storedKey;
  logic        stopEntry;
  logic        arrayDone;
  logic        arrayBlank;
  logic        arrayStart;
  logic [7:0]  arrayCmd;
  logic [15:0] arrayAddr;
  logic [7:0]  arrayData;
  logic        secured;
  logic        debugBlock;
  logic        vectorRedirectEn;
  int          badCount;
  int          nChecks;
  int          startCount;

  flash_command_security_ctrl #(.ADDR_W(16)) i_flash_command_security_ctrl (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .debugAccess(debugAccess),
    .regRdata(regRdata), .flashWr(flashWr), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .nvOptions(nvOptions), .nvProtect(nvProtect),
    .storedKey(storedKey), .stopEntry(stopEntry), .arrayDone(arrayDone),
    .arrayBlank(arrayBlank), .arrayStart(arrayStart), .arrayCmd(arrayCmd),
    .arrayAddr(arrayAddr), .arrayData(arrayData), .secured(secured),
    .debugBlock(debugBlock), .vectorRedirectEn(vectorRedirectEn));

  //==========================================================================
  // Clock and start-pulse counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counting pulses lets refusals be judged after the fact
  always @(posedge clk) begin
    if (arrayStart === 1'b1) startCount <= startCount + 1;
  end

  //==========================================================================
  // Bus and handshake tasks
  task automatic endSim;
    $display("checks=%0d mismatches=%0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : endSim
  task automatic doReset(input logic [7:0] opt);
    rstn      <= 1'b0;
    nvOptions <= opt;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : doReset
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata & m, e)
  endtask : rd
  task automatic dbgWr(input logic [2:0] a, input logic [7:0] d);
    debugAccess <= 1'b1;
    wr(a, d);
    debugAccess <= 1'b0;
  endtask : dbgWr
  task automatic fw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    flashWr    <= 1'b1;
    flashAddr  <= a;
    flashWdata <= d;
    @(posedge clk);
    flashWr <= 1'b0;
  endtask : fw
  task automatic launch(input logic [15:0] a, input logic [7:0] c);
    fw(a, 8'h5A);
    wr(OFS_COMMAND, c);
    wr(OFS_STATUS, 8'h80);
  endtask : launch
  // Bounded wait; running out ends the run as a failure
  task automatic waitStart(input int n0);
    int i;
    for (i = 0; i < 10 && startCount == n0; i++) begin
      @(posedge clk);
      #1;
    end
    if (startCount == n0) begin
      $display("Timeout waiting for array start");
      badCount++;
      endSim();
    end
  endtask : waitStart
  task automatic done(input logic b);
    @(posedge clk);
    arrayDone  <= 1'b1;
    arrayBlank <= b;
    @(posedge clk);
    arrayDone  <= 1'b0;
    arrayBlank <= 1'b0;
  endtask : done
  task automatic run(input logic [15:0] a, input logic [7:0] c,
                     input logic b, input logic [7:0] ef);
    int n0;
    n0 = startCount;
    launch(a, c);
    waitStart(n0);
    `CHK(arrayCmd, c)
    `CHK(arrayAddr, a)
    `CHK(arrayData, 8'h5A)
    rd(OFS_STATUS, 8'h80, 8'hF4);
    done(b);
    rd(OFS_STATUS, ef, 8'hF4);
  endtask : run
  // Launch that must be dropped; flags checked, then cleared by w1c
  task automatic refused(input logic [15:0] a, input logic [7:0] c,
                         input logic [7:0] e);
    int n0;
    n0 = startCount;
    launch(a, c);
    repeat (4) @(posedge clk);
    #1;
    `CHK(startCount, n0)
    rd(OFS_STATUS, e, 8'hF4);
    wr(OFS_STATUS, 8'h30);
    rd(OFS_STATUS, e & 8'hCF, 8'hF4);
  endtask : refused
  task automatic keyEntry(input logic dbg);
    wr(OFS_CONFIG, 8'h20);
    debugAccess <= dbg;
    for (int n = 0; n < KEY_BYTES; n++) begin
      fw(KEY_BASE + 16'(n), storedKey[8*n +: 8]);
    end
    debugAccess <= 1'b0;
    wr(OFS_CONFIG, 8'h00);
    @(posedge clk);
    #1;
  endtask : keyEntry

  //==========================================================================
  // Scenarios
  task automatic tReset;
    rd(OFS_OPTIONS, 8'h80, 8'hFF);
    `CHK(secured, 1'b1)
    `CHK(debugBlock, 1'b1)
    `CHK(vectorRedirectEn, 1'b1)
    rd(OFS_PROTECT, 8'hFF, 8'hFF);
    rd(OFS_STATUS, 8'hC0, 8'hF4);
    rd(OFS_CONFIG, RST_CONFIG, 8'hFF);
    rd(OFS_COMMAND, RST_COMMAND, 8'hFF);
    rd(3'h6, 8'h00, 8'hFF);
    $display("reset values done");
  endtask : tReset
  task automatic tErrors;
    refused(16'h1000, CMD_BYTE_PROG, 8'hD0);
    wr(OFS_DIVIDER, 8'h13);
    rd(OFS_DIVIDER, 8'h93, 8'hFF);
    launch(16'h1000, 8'h33);
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'hD0, 8'hF4);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_STATUS, 8'hC0, 8'hF4);
    $display("access errors done");
  endtask : tErrors
  task automatic tCodes;
    logic [7:0] codes [5];
    codes = '{CMD_BLANK_CHECK, CMD_BYTE_PROG, CMD_BURST_PROG,
              CMD_PAGE_ERASE, CMD_MASS_ERASE};
    for (int i = 0; i < 5; i++) begin
      run(16'h1000 + 16'(i), codes[i], 1'b0, 8'hC0);
    end
    $display("command codes done");
  endtask : tCodes
  task automatic tBurst;
    int n0;
    n0 = startCount;
    launch(16'h1100, CMD_BURST_PROG);
    waitStart(n0);
    launch(16'h1101, CMD_BURST_PROG);
    rd(OFS_STATUS, 8'h00, 8'hF4);
    done(1'b0);
    waitStart(n0 + 1);
    `CHK(arrayAddr, 16'h1101)
    rd(OFS_STATUS, 8'h80, 8'hF4);
    refused(16'h1102, CMD_BYTE_PROG, 8'h90);
    @(posedge clk);
    stopEntry <= 1'b1;
    @(posedge clk);
    stopEntry <= 1'b0;
    rd(OFS_STATUS, 8'h10, 8'h30);
    wr(OFS_STATUS, 8'h10);
    done(1'b0);
    rd(OFS_STATUS, 8'hC0, 8'hF4);
    $display("burst queue done");
  endtask : tBurst
  task automatic tProtect;
    wr(OFS_PROTECT, 8'h00);
    rd(OFS_PROTECT, 8'hFF, 8'hFF);
    dbgWr(OFS_PROTECT, 8'h00);
    rd(OFS_PROTECT, 8'h00, 8'hFF);
    run(16'h01FF, CMD_BYTE_PROG, 1'b0, 8'hC0);
    refused(16'h0200, CMD_BYTE_PROG, 8'hE0);
    refused(16'h0000, CMD_MASS_ERASE, 8'hE0);
    dbgWr(OFS_PROTECT, 8'hFF);
    run(16'hF000, CMD_PAGE_ERASE, 1'b0, 8'hC0);
    $display("protection done");
  endtask : tProtect
  task automatic tKey;
    int n0;
    n0 = startCount;
    keyEntry(1'b1);
    `CHK(secured, 1'b1)
    keyEntry(1'b0);
    `CHK(secured, 1'b0)
    `CHK(debugBlock, 1'b0)
    `CHK(startCount, n0)
    rd(OFS_OPTIONS, 8'h82, 8'hFF);
    $display("backdoor key done");
  endtask : tKey
  task automatic tBlank;
    doReset(8'h40);
    `CHK(vectorRedirectEn, 1'b0)
    `CHK(secured, 1'b1)
    keyEntry(1'b0);
    `CHK(secured, 1'b1)
    wr(OFS_DIVIDER, 8'h01);
    run(16'h0000, CMD_BLANK_CHECK, 1'b1, 8'hC4);
    `CHK(secured, 1'b0)
    rd(OFS_OPTIONS, 8'h42, 8'hFF);
    run(16'h1000, CMD_BYTE_PROG, 1'b0, 8'hC0);
    $display("blank check done");
  endtask : tBlank

  //==========================================================================
  // Main sequence
  initial begin
    badCount    = 0;
    nChecks     = 0;
    startCount  = 0;
    rstn        = 1'b0;
    regAddr     = 3'h0;
    regWdata    = 8'h00;
    regWr       = 1'b0;
    regRd       = 1'b0;
    debugAccess = 1'b0;
    flashWr     = 1'b0;
    flashAddr   = 16'h0000;
    flashWdata  = 8'h00;
    nvOptions   = 8'h80;
    nvProtect   = 8'hFF;
    storedKey   = 64'hF0E1D2C3B4A59687;
    stopEntry   = 1'b0;
    arrayDone   = 1'b0;
    arrayBlank  = 1'b0;
    doReset(8'h80);
    tReset();
    tErrors();
    tCodes();
    tBurst();
    tProtect();
    tKey();
    tBlank();
    endSim();
  end
endmodule : flash_command_security_ctrl_tb
